// file: logic/iss_pkg.sv
// shared constants, state encoding and carrier structs for the two-wire slave engine
package iss_pkg;

    // widths
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 10;
    localparam int ADDR7_W     = 7;
    localparam int ADDR_HI_LSB = 8;
    localparam int PREFIX_LSB  = 3;
    localparam int FIFO_DEPTH  = 16;

    // bit counting within a byte
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_STEP      = 4'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // fixed high bits of a ten-bit address first byte
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

    // reset values
    localparam logic [DATA_W-1:0] DATA_RST    = 8'h00;
    localparam logic              RELEASE_RST = 1'b1;

    // gray codes along idle, address, ack, receive; transmit branch continues the walk
    typedef enum logic [2:0] {
        ISS_IDLE  = 3'h0,
        ISS_ADDR  = 3'h1,
        ISS_ACK   = 3'h3,
        ISS_RX    = 3'h2,
        ISS_TX    = 3'h6,
        ISS_MACK  = 3'h7,
        ISS_ADDR2 = 3'h5
    } iss_state_t;

    // static configuration from software
    typedef struct packed {
        logic              module_on_bit;
        logic              ten_bit_addr_mode;
        logic              stretch_enable;
        logic [ADDR_W-1:0] own_address_reg;
    } iss_ctrl_t;

    // status seen by software
    typedef struct packed {
        logic [DATA_W-1:0] receive_buffer;
        logic              rx_buffer_full;
        logic              tx_buffer_full;
        logic              rx_overflow_flag;
        logic              clock_release_bit;
        logic              ten_bit_match_flag;
    } iss_status_t;

endpackage

// file: logic/iss_fifo.sv
// parameterised valid/ready fifo held in flip-flops
`timescale 1ns/1ps
module iss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] ZERO_CNT = CW'(0);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign push       = in_valid_i & in_ready_o;
    assign pop        = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_comb begin
        case ({push, pop})
            2'b10:   next_count = count + CW'(1);
            2'b01:   next_count = count - CW'(1);
            default: next_count = count;
        endcase
    end

    // storage has no reset: nothing reads a slot before it is written
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= ZERO_CNT;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
            end
            count       <= next_count;
            in_ready_o  <= (next_count != FULL_CNT);
            out_valid_o <= (next_count != ZERO_CNT);
        end
    end

endmodule // iss_fifo

// file: logic/iss_slave_top.sv
// two-wire bus slave engine: addressing, byte transfer and clock stretching
`timescale 1ns/1ps
module iss_slave_top (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // bus pins, open drain
    input  wire logic                   scl_i,
    output logic                        scl_o,
    output logic                        scl_oe_o,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_o,
    // configuration
    input  wire iss_pkg::iss_ctrl_t     ctrl_i,
    // software strobes
    input  wire logic                   rx_read_i,
    input  wire logic                   overflow_clear_i,
    input  wire logic                   release_set_i,
    input  wire logic                   release_clear_i,
    // transmit data stream
    input  wire logic                   tx_valid_i,
    input  wire logic [7:0]             tx_data_i,
    output logic                        tx_ready_o,
    // status and events
    output iss_pkg::iss_status_t        status_o,
    output logic                        slave_event_flag_o,
    output logic                        master_event_flag_o
);
    localparam int NPIN = 2;

    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic            scl_s;
    logic            sda_s;
    logic            scl_p;
    logic            sda_p;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_det;
    logic            stop_det;

    // sequencing
    iss_pkg::iss_state_t state;
    iss_pkg::iss_state_t ack_next;
    iss_pkg::iss_state_t addr_next;
    logic [3:0]      bitcnt;
    logic [7:0]      rx_shift_reg;
    logic            ack_drive;
    logic            ack_data;
    logic            master_ack;
    logic            addr_ok;
    logic            hi_ok;
    logic            byte_done;
    logic            ack9_fall;
    logic            mack_fall;

    // buffers and flags
    logic [7:0]      receive_buffer;
    logic            rx_buffer_full;
    logic            rx_overflow_flag;
    logic [7:0]      transmit_register;
    logic            tx_buffer_full;
    logic [7:0]      tx_shift;
    logic            tx_loaded;
    logic            clock_release_bit;
    logic            ten_bit_match_flag;
    logic            auto_clear;
    logic            fifo_valid;
    logic [7:0]      fifo_data;
    logic            fifo_pop;
    logic            tx_start;
    logic            on;

    assign on      = ctrl_i.module_on_bit;
    assign pin_raw = {scl_i, sda_i};
    assign scl_s   = pin_sync[1];
    assign sda_s   = pin_sync[0];

    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pin_meta[g] <= 1'b1;
                    pin_sync[g] <= 1'b1;
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

    assign byte_done = scl_fall && (bitcnt == iss_pkg::BITS_PER_BYTE)
                       && (state == iss_pkg::ISS_ADDR || state == iss_pkg::ISS_ADDR2 || state == iss_pkg::ISS_RX);
    assign ack9_fall = scl_fall && (state == iss_pkg::ISS_ACK);
    assign mack_fall = scl_fall && (state == iss_pkg::ISS_MACK);

    // address decode on the completed byte
    always_comb begin
        hi_ok = (rx_shift_reg[iss_pkg::DATA_W-1:iss_pkg::PREFIX_LSB] == iss_pkg::TEN_BIT_PREFIX)
                && (rx_shift_reg[2:1] == ctrl_i.own_address_reg[iss_pkg::ADDR_W-1:iss_pkg::ADDR_HI_LSB]);
        addr_ok   = 1'b0;
        addr_next = iss_pkg::ISS_IDLE;
        case (state)
            iss_pkg::ISS_ADDR: begin
                if (!ctrl_i.ten_bit_addr_mode) begin
                    addr_ok   = (rx_shift_reg[iss_pkg::DATA_W-1:1]
                                 == ctrl_i.own_address_reg[iss_pkg::ADDR7_W-1:0]);
                    addr_next = rx_shift_reg[0] ? iss_pkg::ISS_TX : iss_pkg::ISS_RX;
                end else if (hi_ok && !rx_shift_reg[0]) begin
                    addr_ok   = 1'b1;
                    addr_next = iss_pkg::ISS_ADDR2;
                end else if (hi_ok && rx_shift_reg[0] && ten_bit_match_flag) begin
                    addr_ok   = 1'b1;
                    addr_next = iss_pkg::ISS_TX;
                end
            end
            iss_pkg::ISS_ADDR2: begin
                addr_ok   = (rx_shift_reg == ctrl_i.own_address_reg[iss_pkg::DATA_W-1:0]);
                addr_next = iss_pkg::ISS_RX;
            end
            default: begin
                addr_ok   = 1'b0;
                addr_next = iss_pkg::ISS_IDLE;
            end
        endcase
    end

    // main sequencer; a start anywhere restarts address collection
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= iss_pkg::ISS_IDLE;
            ack_next     <= iss_pkg::ISS_IDLE;
            bitcnt       <= iss_pkg::BIT_ZERO;
            rx_shift_reg <= iss_pkg::DATA_RST;
            ack_drive    <= 1'b0;
            ack_data     <= 1'b0;
            master_ack   <= 1'b0;
        end else if (!on || stop_det) begin
            state     <= iss_pkg::ISS_IDLE;
            ack_drive <= 1'b0;
        end else if (start_det) begin
            state  <= iss_pkg::ISS_ADDR;
            bitcnt <= iss_pkg::BIT_ZERO;
        end else begin
            case (state)
                iss_pkg::ISS_ADDR, iss_pkg::ISS_ADDR2, iss_pkg::ISS_RX: begin
                    if (scl_rise) begin
                        rx_shift_reg <= {rx_shift_reg[iss_pkg::DATA_W-2:0], sda_s};
                        bitcnt       <= bitcnt + iss_pkg::BIT_STEP;
                    end else if (byte_done) begin
                        if (state == iss_pkg::ISS_RX) begin
                            state     <= iss_pkg::ISS_ACK;
                            ack_next  <= iss_pkg::ISS_RX;
                            ack_data  <= 1'b1;
                            ack_drive <= !rx_buffer_full && !rx_overflow_flag;
                        end else if (addr_ok) begin
                            state     <= iss_pkg::ISS_ACK;
                            ack_next  <= addr_next;
                            ack_data  <= 1'b0;
                            ack_drive <= 1'b1;
                        end else begin
                            state <= iss_pkg::ISS_IDLE;
                        end
                    end
                end
                iss_pkg::ISS_ACK: begin
                    if (scl_fall) begin
                        state     <= ack_next;
                        bitcnt    <= iss_pkg::BIT_ZERO;
                        ack_drive <= 1'b0;
                    end
                end
                iss_pkg::ISS_TX: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + iss_pkg::BIT_STEP;
                    end else if (scl_fall && bitcnt == iss_pkg::BITS_PER_BYTE) begin
                        state <= iss_pkg::ISS_MACK;
                    end
                end
                iss_pkg::ISS_MACK: begin
                    if (scl_rise) begin
                        master_ack <= !sda_s;
                    end else if (scl_fall) begin
                        state  <= master_ack ? iss_pkg::ISS_TX : iss_pkg::ISS_IDLE;
                        bitcnt <= iss_pkg::BIT_ZERO;
                    end
                end
                default: begin
                    bitcnt <= iss_pkg::BIT_ZERO;
                end
            endcase
        end
    end

    // ten-bit match flag; cleared by a stop so a fresh read cannot ride an old match
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ten_bit_match_flag <= 1'b0;
        end else if (!on || !ctrl_i.ten_bit_addr_mode || stop_det) begin
            ten_bit_match_flag <= 1'b0;
        end else if (byte_done && state == iss_pkg::ISS_ADDR2) begin
            ten_bit_match_flag <= addr_ok;
        end else if (byte_done && state == iss_pkg::ISS_ADDR) begin
            ten_bit_match_flag <= addr_ok && rx_shift_reg[0];
        end
    end

    // receive buffer and its flags; hardware set wins over software clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            receive_buffer   <= iss_pkg::DATA_RST;
            rx_buffer_full   <= 1'b0;
            rx_overflow_flag <= 1'b0;
        end else begin
            if (byte_done && state == iss_pkg::ISS_RX && !rx_buffer_full) begin
                receive_buffer <= rx_shift_reg;
                rx_buffer_full <= 1'b1;
            end else if (rx_read_i) begin
                rx_buffer_full <= 1'b0;
            end
            if (byte_done && state == iss_pkg::ISS_RX && rx_buffer_full) begin
                rx_overflow_flag <= 1'b1;
            end else if (overflow_clear_i) begin
                rx_overflow_flag <= 1'b0;
            end
        end
    end

    // transmit register is fed from the fifo only while empty, so the fifo fills under stretch
    assign fifo_pop = fifo_valid && !tx_buffer_full;
    assign tx_start = (state == iss_pkg::ISS_TX) && !tx_loaded && tx_buffer_full;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_register <= iss_pkg::DATA_RST;
            tx_buffer_full    <= 1'b0;
        end else if (fifo_pop) begin
            transmit_register <= fifo_data;
            tx_buffer_full    <= 1'b1;
        end else if (tx_start) begin
            tx_buffer_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_shift  <= iss_pkg::DATA_RST;
            tx_loaded <= 1'b0;
        end else if (state != iss_pkg::ISS_TX && state != iss_pkg::ISS_MACK) begin
            tx_loaded <= 1'b0;
        end else if (mack_fall) begin
            tx_loaded <= 1'b0;
        end else if (tx_start) begin
            tx_shift  <= transmit_register;
            tx_loaded <= 1'b1;
        end else if (scl_fall && state == iss_pkg::ISS_TX && bitcnt != iss_pkg::BITS_PER_BYTE) begin
            tx_shift <= {tx_shift[iss_pkg::DATA_W-2:0], 1'b1};
        end
    end

    // automatic release clears at the ninth falling edge
    always_comb begin
        auto_clear = 1'b0;
        if (ack9_fall) begin
            if (ack_next == iss_pkg::ISS_TX) begin
                auto_clear = !tx_buffer_full;
            end else if (ack_next == iss_pkg::ISS_RX && ack_data) begin
                auto_clear = ctrl_i.stretch_enable && rx_buffer_full;
            end else if (ack_next == iss_pkg::ISS_ADDR2) begin
                auto_clear = ctrl_i.stretch_enable;
            end
        end else if (mack_fall) begin
            auto_clear = master_ack && !tx_buffer_full;
        end
    end

    // hardware clear wins over a software set in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clock_release_bit <= iss_pkg::RELEASE_RST;
        end else if (!on) begin
            clock_release_bit <= iss_pkg::RELEASE_RST;
        end else if (auto_clear) begin
            clock_release_bit <= 1'b0;
        end else if (release_set_i) begin
            clock_release_bit <= 1'b1;
        end else if (release_clear_i && ctrl_i.stretch_enable) begin
            clock_release_bit <= 1'b0;
        end
    end

    // hold only once the line is seen low, so the high time is never cut short
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_oe_o <= 1'b0;
        end else begin
            scl_oe_o <= on && !clock_release_bit && (scl_oe_o || !scl_s);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_oe_o <= 1'b0;
        end else begin
            sda_oe_o <= on && ((state == iss_pkg::ISS_ACK && ack_drive)
                               || (state == iss_pkg::ISS_TX && tx_loaded && !tx_shift[iss_pkg::DATA_W-1]));
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // no master engine here, so the master event never fires
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slave_event_flag_o  <= 1'b0;
            master_event_flag_o <= 1'b0;
        end else begin
            slave_event_flag_o  <= ack9_fall || mack_fall;
            master_event_flag_o <= 1'b0;
        end
    end

    assign status_o = '{
        receive_buffer:     receive_buffer,
        rx_buffer_full:     rx_buffer_full,
        tx_buffer_full:     tx_buffer_full,
        rx_overflow_flag:   rx_overflow_flag,
        clock_release_bit:  clock_release_bit,
        ten_bit_match_flag: ten_bit_match_flag
    };

    iss_fifo #(
        .WIDTH (iss_pkg::DATA_W),
        .DEPTH (iss_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_data_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

endmodule // iss_slave_top

// file: dv/iss_slave_props.sv
// concurrent checks on the slave engine ports
`timescale 1ns/1ps
module iss_slave_props (
    // clock and reset
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    // pins and strobes
    input wire logic                 scl_i,
    input wire logic                 scl_oe_o,
    input wire logic                 sda_oe_o,
    input wire iss_pkg::iss_ctrl_t   ctrl_i,
    input wire logic                 rx_read_i,
    input wire logic                 overflow_clear_i,
    input wire logic                 release_set_i,
    input wire logic                 release_clear_i,
    // status and events
    input wire iss_pkg::iss_status_t status_o,
    input wire logic                 slave_event_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_event_one_cycle: assert property (slave_event_flag_o |=> !slave_event_flag_o)
        else $error("slave event wider than one cycle");
    // data may only move while the clock pin is low, else it reads as start or stop
    chk_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed with clock high");
    chk_stretch_hold: assert property (status_o.clock_release_bit && $past(status_o.clock_release_bit) |-> !scl_oe_o)
        else $error("clock held low with release set");
    chk_sw_clear_ignored: assert property (release_clear_i && !ctrl_i.stretch_enable && status_o.clock_release_bit |=> status_o.clock_release_bit)
        else $error("release cleared with stretching off");
    chk_release_set: assert property (release_set_i |=> status_o.clock_release_bit)
        else $error("release set ignored");
    chk_read_clears: assert property (rx_read_i |=> !status_o.rx_buffer_full)
        else $error("buffer read left full flag set");
    chk_overflow_sticky: assert property (status_o.rx_overflow_flag && !overflow_clear_i |=> status_o.rx_overflow_flag)
        else $error("overflow flag dropped by itself");
    chk_full_no_load: assert property (status_o.rx_buffer_full && !rx_read_i |=> status_o.rx_buffer_full && $stable(status_o.receive_buffer))
        else $error("full buffer overwritten");
endmodule // iss_slave_props

bind iss_slave_top iss_slave_props iss_slave_props_inst (.clk_i, .rst_n_i, .scl_i, .scl_oe_o, .sda_oe_o, .ctrl_i,
    .rx_read_i, .overflow_clear_i, .release_set_i, .release_clear_i, .status_o, .slave_event_flag_o);

// file: dv/iss_master_model.sv
// behavioural bus master pulling the two-wire pins low, open drain
`timescale 1ns/1ps
module iss_master_model (
    // wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // pull-down enables
    output logic      scl_low_o,
    output logic      sda_low_o
);
    // clock waits that ran out of their bound; the bench counts each as a mismatch
    int stall_cnt = 0;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    // start or repeated start: data falls while clock high
    task automatic start_cond;
        sda_low_o = 1'b0;
        #40;
        scl_low_o = 1'b0;
        #80;
        sda_low_o = 1'b1;
        #80;
        scl_low_o = 1'b1;
        #40;
    endtask
    task automatic stop_cond;
        sda_low_o = 1'b1;
        #40;
        scl_low_o = 1'b0;
        #80;
        sda_low_o = 1'b0;
        #80;
    endtask
    // data set mid-low; waits out a stretched low, bounded so a stuck clock cannot hang
    task automatic clk_bit(input logic b, output logic s);
        sda_low_o = !b;
        #40;
        scl_low_o = 1'b0;
        for (int n = 0; n < 5000 && !scl_i; n++) #8;
        if (!scl_i) stall_cnt++;
        #80;
        s = sda_i;
        scl_low_o = 1'b1;
        #40;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] got, output logic nack);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], got[i]);
        clk_bit(ack, nack);
    endtask
endmodule // iss_master_model

// file: dv/iss_slave_top_tb.sv
// self-checking bench for the two-wire slave engine
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module iss_slave_top_tb;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [3:0]          sw = 4'h0;
    logic                tx_valid = 1'b0;
    logic [7:0]          tx_data = 8'h00;
    iss_pkg::iss_ctrl_t  ctrl = '0;
    iss_pkg::iss_status_t status;
    logic                scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, tx_ready, evp, mevt;
    wire logic           scl = !(scl_oe && !scl_o) && !m_scl;
    wire logic           sda = !(sda_oe && !sda_o) && !m_sda;
    int                  errors = 0;
    int                  tests_run = 0;
    int                  ev = 0;
    logic [7:0]          g;
    logic                k;
    int                  e;
    always #4 clk = !clk;
    always @(posedge clk) if (evp) ev <= ev + 1;
    iss_slave_top iss_slave_top_inst (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .ctrl_i(ctrl), .rx_read_i(sw[0]), .overflow_clear_i(sw[1]),
        .release_set_i(sw[2]), .release_clear_i(sw[3]), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .status_o(status), .slave_event_flag_o(evp), .master_event_flag_o(mevt));
    iss_master_model m (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // strobe bits: read, overflow clear, release set, release clear
    task automatic pulse(input logic [3:0] v);
        sw = v;
        tick(1);
        sw = 4'h0;
        tick(1);
    endtask
    task automatic push(input logic [7:0] d);
        int n;
        n = 0;
        tx_data = d;
        tx_valid = 1'b1;
        @(posedge clk);
        while (!tx_ready && n < 50) begin
            n++;
            @(posedge clk);
        end
        #1;
        tx_valid = 1'b0;
        tick(1);
        `CHK(tx_ready, 1'b1)
    endtask
    task automatic conclude;
        errors += m.stall_cnt;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_write7;
        ctrl = '{1'b1, 1'b0, 1'b0, 10'h05a};
        tick(2);
        e = ev;
        m.start_cond();
        m.xfer(8'hb4, 1'b1, g, k);
        tick(3);
        `CHK({k, status.rx_buffer_full, ev == e + 1}, 3'b001)
        m.xfer(8'hc3, 1'b1, g, k);
        tick(3);
        `CHK({k, status.rx_buffer_full, status.receive_buffer}, {2'b01, 8'hc3})
        m.xfer(8'h3c, 1'b1, g, k);
        tick(3);
        `CHK({k, status.rx_overflow_flag, status.receive_buffer, ev == e + 3}, {2'b11, 8'hc3, 1'b1})
        pulse(4'h1);
        `CHK(status.rx_buffer_full, 1'b0)
        m.xfer(8'h77, 1'b1, g, k);
        m.stop_cond();
        `CHK({k, status.receive_buffer}, {1'b1, 8'h77})
        pulse(4'h3);
        `CHK({status.rx_buffer_full, status.rx_overflow_flag, mevt}, 3'b000)
    endtask
    task automatic t_read7;
        e = ev;
        m.start_cond();
        m.xfer(8'hb5, 1'b1, g, k);
        tick(10);
        `CHK({k, scl_oe, status.clock_release_bit}, 3'b010)
        push(8'ha5);
        push(8'h5a);
        push(8'h66);
        `CHK({scl_oe, status.tx_buffer_full}, 2'b11)
        pulse(4'h4);
        tick(1);
        `CHK(scl_oe, 1'b0)
        m.xfer(8'hff, 1'b0, g, k);
        tick(3);
        `CHK({g, status.clock_release_bit}, {8'ha5, 1'b1})
        m.xfer(8'hff, 1'b0, g, k);
        `CHK(g, 8'h5a)
        m.xfer(8'hff, 1'b1, g, k);
        tick(3);
        `CHK({g, ev == e + 4}, {8'h66, 1'b1})
        m.stop_cond();
    endtask
    task automatic t_ten;
        ctrl = '{1'b1, 1'b1, 1'b1, 10'h2c7};
        tick(2);
        e = ev;
        m.start_cond();
        m.xfer(8'hf4, 1'b1, g, k);
        tick(10);
        `CHK({k, status.ten_bit_match_flag, scl_oe}, 3'b001)
        pulse(4'h4);
        m.xfer(8'hc7, 1'b1, g, k);
        tick(3);
        `CHK({k, status.ten_bit_match_flag}, 2'b01)
        m.xfer(8'h11, 1'b1, g, k);
        tick(10);
        `CHK({k, scl_oe, status.receive_buffer}, {2'b01, 8'h11})
        pulse(4'h1);
        pulse(4'h4);
        // read the buffer between its load and the ninth fall: no stretch may follow
        fork
            m.xfer(8'h22, 1'b1, g, k);
            begin
                for (int n = 0; n < 400 && !status.rx_buffer_full; n++) tick(1);
                `CHK(status.rx_buffer_full, 1'b1)
                pulse(4'h1);
            end
        join
        tick(10);
        `CHK({k, scl_oe, status.rx_buffer_full, status.receive_buffer}, {3'b000, 8'h22})
        m.start_cond();
        m.xfer(8'hf5, 1'b1, g, k);
        tick(10);
        `CHK({k, scl_oe}, 2'b01)
        push(8'h9e);
        pulse(4'h4);
        m.xfer(8'hff, 1'b1, g, k);
        m.stop_cond();
        `CHK({g, ev == e + 6}, {8'h9e, 1'b1})
    endtask
    task automatic t_soft_and_refuse;
        ctrl = '{1'b1, 1'b0, 1'b0, 10'h05a};
        tick(2);
        pulse(4'h8);
        `CHK(status.clock_release_bit, 1'b1)
        ctrl.stretch_enable = 1'b1;
        tick(2);
        pulse(4'h8);
        `CHK({status.clock_release_bit, scl_oe}, 2'b00)
        pulse(4'h4);
        e = ev;
        m.start_cond();
        m.xfer(8'hb6, 1'b1, g, k);
        m.stop_cond();
        `CHK(k, 1'b1)
        ctrl.module_on_bit = 1'b0;
        tick(2);
        m.start_cond();
        m.xfer(8'hb4, 1'b1, g, k);
        m.stop_cond();
        `CHK({k, ev == e}, 2'b11)
    endtask
    initial begin
        tick(3);
        rst_n = 1'b1;
        tick(3);
        t_write7();
        t_read7();
        t_ten();
        t_soft_and_refuse();
        conclude();
    end
    // a stuck clock stretch would otherwise drag the run out by a 40 us wait per bit
    initial begin
        #500us;
        errors++;
        conclude();
    end
endmodule // iss_slave_top_tb
